// >>> common/nvipst_pkg.sv
// constants shared by the interrupt pending state tracker
package nvipst_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_SET_PEND = 8'h00;
	localparam logic [7:0] OFS_CLR_PEND = 8'h04;
	localparam logic [7:0] OFS_ACTIVE = 8'h08;
	localparam logic [7:0] OFS_TYPE = 8'h0C;
	localparam logic [7:0] OFS_SOFTWARE_IRQ_TRIGGER = 8'h10;
	localparam logic [7:0] OFS_ENABLE = 8'h14;
	localparam logic [7:0] OFS_PRIO0 = 8'h20;
	localparam logic [7:0] OFS_PRIO1 = 8'h24;
	localparam logic [7:0] OFS_PRIO2 = 8'h28;
	localparam logic [7:0] OFS_PRIO3 = 8'h2C;
	localparam logic [7:0] OFS_EVT_STAT = 8'h30;
	localparam logic [7:0] OFS_EVT_MASK = 8'h34;
	localparam logic [7:0] OFS_ARB = 8'h38;
	localparam int ADDR_DEC_W = 8;
	// priority fields: 3 bits used in a 4-bit slot, 8 slots per word
	localparam int PRIO_W = 3;
	localparam int PRIO_SLOT_W = 4;
	localparam int PRIOS_PER_WORD = 8;
	localparam int PRIO_WORDS = 4;
	localparam logic [2:0] PRIO_RST = 3'h0;
	// event status bits
	localparam int EVT_W = 3;
	localparam int EVT_RAISE = 0;
	localparam int EVT_NEST = 1;
	localparam int EVT_BLOCKED = 2;
	localparam logic [2:0] EVT_MASK_RST = 3'h0;
	// arbiter status word layout
	localparam int ARB_VALID_BIT = 31;
	localparam int ARB_PRIO_LSB = 8;
	// ahb constants
	localparam int HTRANS_SEQ_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [31:0] HRDATA_RST = 32'h0000_0000;
	localparam int MAX_IRQ = 32;
endpackage

// >>> src/nvipst_line_cell.sv
// pending and active state of one interrupt line
`timescale 1ns/1ps
module nvipst_line_cell (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_req,
	input wire logic i_pulse_mode,
	input wire logic i_sw_set,
	input wire logic i_sw_clr,
	input wire logic i_enter,
	input wire logic i_return,
	output logic o_pending,
	output logic o_active,
	output logic o_evt_raise,
	output logic o_evt_nest,
	output logic o_evt_blocked
);
	logic req_q_ff;
	logic pend_ff;
	logic act_ff;
	logic nxt_req_q;
	logic nxt_pend;
	logic nxt_act;
	logic rise;
	logic hw_set;

	always_comb begin
		nxt_req_q = i_req;
		// pulse seen on this rising edge, held in pend_ff
		rise = i_req & ~req_q_ff;
		hw_set = rise;
		if (!i_pulse_mode && i_req && !act_ff && !i_enter) begin
			hw_set = 1'b1;
		end
		nxt_pend = pend_ff;
		nxt_act = act_ff;
		o_evt_blocked = 1'b0;
		if (i_sw_clr) begin
			if (i_pulse_mode) begin
				nxt_pend = 1'b0;
			end else if (!i_req) begin
				nxt_pend = 1'b0;
			end else begin
				o_evt_blocked = pend_ff;
			end
		end
		if (i_return) begin
			nxt_act = 1'b0;
			if (!i_pulse_mode) begin
				nxt_pend = i_req;
			end
			// pulse lines keep whatever pending state the service window left
		end
		if (i_enter) begin
			nxt_pend = 1'b0;
			nxt_act = 1'b1;
		end
		// sets come last so an event in the clearing cycle survives
		if (hw_set || i_sw_set) begin
			nxt_pend = 1'b1;
		end
		o_evt_raise = hw_set & ~pend_ff;
		o_evt_nest = i_pulse_mode & rise & (act_ff | i_enter);
		o_pending = pend_ff;
		o_active = act_ff;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_q_ff <= 1'b0;
			pend_ff <= 1'b0;
			act_ff <= 1'b0;
		end else begin
			req_q_ff <= nxt_req_q;
			pend_ff <= nxt_pend;
			act_ff <= nxt_act;
		end
	end
endmodule

// >>> src/nvipst_arbiter.sv
// picks the most urgent candidate; ties go to the lowest number
`timescale 1ns/1ps
module nvipst_arbiter #(
	parameter int N_IRQ = 21,
	parameter int ID_W = 5
) (
	input wire logic [N_IRQ-1:0] i_cand,
	input wire logic [N_IRQ-1:0][nvipst_pkg::PRIO_W-1:0] i_prio,
	output logic o_valid,
	output logic [ID_W-1:0] o_id,
	output logic [nvipst_pkg::PRIO_W-1:0] o_prio
);
	always_comb begin
		o_valid = 1'b0;
		o_id = '0;
		o_prio = '1;
		for (int k = 0; k < N_IRQ; k++) begin
			// strictly smaller level wins, level 0 beats all
			if (i_cand[k] && (!o_valid || i_prio[k] < o_prio)) begin
				o_valid = 1'b1;
				o_id = ID_W'(k);
				o_prio = i_prio[k];
			end
		end
	end
endmodule

// >>> src/nvipst_top.sv
// interrupt pending state tracker with ahb-lite register slave
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Contract
// - each line holds priority level 0 to 7
// - smaller level is more urgent, zero wins
// - pulse inputs sampled on clock, pulse latched
// - level line high while not active sets pending
// - rising edge on line sets pending
// - software set or trigger sets pending
// - service entry clears pending, sets active
// - level return: pending if line high, else inactive
// - pulse during service: pending and active, pending after
// - no pulse during service: inactive after return
// - level clear ignored while line high
// - pulse clear drops pending, keeps active
module nvipst_top #(
	parameter int N_IRQ = 21
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [N_IRQ-1:0] i_irq_line,
	input wire logic i_enter,
	input wire logic [$clog2(N_IRQ)-1:0] i_enter_id,
	input wire logic i_return,
	input wire logic [$clog2(N_IRQ)-1:0] i_return_id,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	output logic o_irq_req,
	output logic [$clog2(N_IRQ)-1:0] o_irq_id,
	output logic [nvipst_pkg::PRIO_W-1:0] o_irq_prio,
	output logic o_int
);
	localparam int ID_W = $clog2(N_IRQ);
	localparam int PW = nvipst_pkg::PRIO_W;
	localparam int AW = nvipst_pkg::ADDR_DEC_W;

	// refuse line counts that the register words cannot hold
	if (N_IRQ < 2 || N_IRQ > nvipst_pkg::MAX_IRQ) begin : g_bad_count
		$error("N_IRQ must lie between 2 and 32");
	end

	// reset release
	logic rst_meta_ff;
	logic rst_sync_ff;
	logic rst_n;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	// register and bus state
	logic [N_IRQ-1:0] enable_ff;
	logic [N_IRQ-1:0] type_ff;
	logic [N_IRQ-1:0][PW-1:0] prio_ff;
	logic [nvipst_pkg::EVT_W-1:0] evt_stat_ff;
	logic [nvipst_pkg::EVT_W-1:0] evt_mask_ff;
	logic dp_wr_ff;
	logic [AW-1:0] dp_addr_ff;
	logic [31:0] hrdata_ff;
	logic irq_req_ff;
	logic [ID_W-1:0] irq_id_ff;
	logic [PW-1:0] irq_prio_ff;
	logic int_ff;

	logic [N_IRQ-1:0] nxt_enable;
	logic [N_IRQ-1:0] nxt_type;
	logic [N_IRQ-1:0][PW-1:0] nxt_prio;
	logic [nvipst_pkg::EVT_W-1:0] nxt_evt_stat;
	logic [nvipst_pkg::EVT_W-1:0] nxt_evt_mask;
	logic nxt_dp_wr;
	logic [AW-1:0] nxt_dp_addr;
	logic [31:0] nxt_hrdata;
	logic nxt_irq_req;
	logic [ID_W-1:0] nxt_irq_id;
	logic [PW-1:0] nxt_irq_prio;
	logic nxt_int;

	// per-line wiring
	logic [N_IRQ-1:0] sw_set;
	logic [N_IRQ-1:0] sw_clr;
	logic [N_IRQ-1:0] enter_vec;
	logic [N_IRQ-1:0] return_vec;
	logic [N_IRQ-1:0] pending;
	logic [N_IRQ-1:0] active;
	logic [N_IRQ-1:0] ev_raise;
	logic [N_IRQ-1:0] ev_nest;
	logic [N_IRQ-1:0] ev_blocked;
	logic arb_valid;
	logic [ID_W-1:0] arb_id;
	logic [PW-1:0] arb_prio;
	logic addr_phase;
	logic [AW-1:0] wa;
	logic [AW-1:0] ra;
	logic [31:0] prio_word;
	logic [N_IRQ-1:0] one_hot_base;

	assign one_hot_base = N_IRQ'(1);

	genvar g;
	generate
		for (g = 0; g < N_IRQ; g++) begin : g_line
			nvipst_line_cell u_cell (
				.i_clk(i_ref_clk),
				.i_rst_n(rst_n),
				.i_req(i_irq_line[g]),
				.i_pulse_mode(type_ff[g]),
				.i_sw_set(sw_set[g]),
				.i_sw_clr(sw_clr[g]),
				.i_enter(enter_vec[g]),
				.i_return(return_vec[g]),
				.o_pending(pending[g]),
				.o_active(active[g]),
				.o_evt_raise(ev_raise[g]),
				.o_evt_nest(ev_nest[g]),
				.o_evt_blocked(ev_blocked[g])
			);
		end
	endgenerate

	nvipst_arbiter #(
		.N_IRQ(N_IRQ),
		.ID_W(ID_W)
	) u_arb (
		.i_cand(pending & enable_ff & ~active),
		.i_prio(prio_ff),
		.o_valid(arb_valid),
		.o_id(arb_id),
		.o_prio(arb_prio)
	);

	// core entry and return strobes, one-hot per line
	always_comb begin
		enter_vec = i_enter ? (one_hot_base << i_enter_id) : '0;
		return_vec = i_return ? (one_hot_base << i_return_id) : '0;
	end

	// data-phase write decode
	always_comb begin
		wa = dp_addr_ff;
		sw_set = '0;
		sw_clr = '0;
		nxt_enable = enable_ff;
		nxt_type = type_ff;
		nxt_prio = prio_ff;
		nxt_evt_mask = evt_mask_ff;
		nxt_evt_stat = evt_stat_ff;
		if (dp_wr_ff) begin
			case (wa)
				nvipst_pkg::OFS_SET_PEND: begin
					sw_set = i_hwdata[N_IRQ-1:0];
				end
				nvipst_pkg::OFS_CLR_PEND: begin
					sw_clr = i_hwdata[N_IRQ-1:0];
				end
				nvipst_pkg::OFS_SOFTWARE_IRQ_TRIGGER: begin
					// compare as int so a full power-of-two line count is not cut to zero
					if (int'(i_hwdata[ID_W-1:0]) < N_IRQ) begin
						sw_set = one_hot_base << i_hwdata[ID_W-1:0];
					end
				end
				nvipst_pkg::OFS_TYPE: begin
					nxt_type = i_hwdata[N_IRQ-1:0];
				end
				nvipst_pkg::OFS_ENABLE: begin
					nxt_enable = i_hwdata[N_IRQ-1:0];
				end
				nvipst_pkg::OFS_EVT_MASK: begin
					nxt_evt_mask = i_hwdata[nvipst_pkg::EVT_W-1:0];
				end
				nvipst_pkg::OFS_EVT_STAT: begin
					nxt_evt_stat = evt_stat_ff & ~i_hwdata[nvipst_pkg::EVT_W-1:0];
				end
				default: begin
				end
			endcase
			for (int k = 0; k < N_IRQ; k++) begin
				if (wa == nvipst_pkg::OFS_PRIO0 + AW'((k / nvipst_pkg::PRIOS_PER_WORD) * 4)) begin
					nxt_prio[k] = i_hwdata[(k % nvipst_pkg::PRIOS_PER_WORD) * nvipst_pkg::PRIO_SLOT_W +: PW];
				end
			end
		end
		// new events win over a same-cycle clear
		nxt_evt_stat[nvipst_pkg::EVT_RAISE] = nxt_evt_stat[nvipst_pkg::EVT_RAISE] | (|ev_raise);
		nxt_evt_stat[nvipst_pkg::EVT_NEST] = nxt_evt_stat[nvipst_pkg::EVT_NEST] | (|ev_nest);
		nxt_evt_stat[nvipst_pkg::EVT_BLOCKED] = nxt_evt_stat[nvipst_pkg::EVT_BLOCKED] | (|ev_blocked);
	end

	// address phase capture and read data, zero wait states
	always_comb begin
		addr_phase = i_hsel & i_htrans[nvipst_pkg::HTRANS_SEQ_BIT] & i_hready;
		ra = i_haddr[AW-1:0];
		nxt_dp_wr = addr_phase & i_hwrite;
		nxt_dp_addr = addr_phase ? ra : dp_addr_ff;
		prio_word = '0;
		for (int k = 0; k < N_IRQ; k++) begin
			if (ra == nvipst_pkg::OFS_PRIO0 + AW'((k / nvipst_pkg::PRIOS_PER_WORD) * 4)) begin
				prio_word[(k % nvipst_pkg::PRIOS_PER_WORD) * nvipst_pkg::PRIO_SLOT_W +: PW] = prio_ff[k];
			end
		end
		nxt_hrdata = hrdata_ff;
		if (addr_phase && !i_hwrite) begin
			nxt_hrdata = '0;
			case (ra)
				nvipst_pkg::OFS_SET_PEND,
				nvipst_pkg::OFS_CLR_PEND: begin
					nxt_hrdata[N_IRQ-1:0] = pending;
				end
				nvipst_pkg::OFS_ACTIVE: begin
					nxt_hrdata[N_IRQ-1:0] = active;
				end
				nvipst_pkg::OFS_TYPE: begin
					nxt_hrdata[N_IRQ-1:0] = type_ff;
				end
				nvipst_pkg::OFS_ENABLE: begin
					nxt_hrdata[N_IRQ-1:0] = enable_ff;
				end
				nvipst_pkg::OFS_PRIO0,
				nvipst_pkg::OFS_PRIO1,
				nvipst_pkg::OFS_PRIO2,
				nvipst_pkg::OFS_PRIO3: begin
					nxt_hrdata = prio_word;
				end
				nvipst_pkg::OFS_EVT_STAT: begin
					nxt_hrdata[nvipst_pkg::EVT_W-1:0] = evt_stat_ff;
				end
				nvipst_pkg::OFS_EVT_MASK: begin
					nxt_hrdata[nvipst_pkg::EVT_W-1:0] = evt_mask_ff;
				end
				nvipst_pkg::OFS_ARB: begin
					nxt_hrdata[nvipst_pkg::ARB_VALID_BIT] = irq_req_ff;
					nxt_hrdata[nvipst_pkg::ARB_PRIO_LSB +: PW] = irq_prio_ff;
					nxt_hrdata[ID_W-1:0] = irq_id_ff;
				end
				default: begin
					nxt_hrdata = '0;
				end
			endcase
		end
	end

	// request to the core and interrupt line
	always_comb begin
		nxt_irq_req = arb_valid;
		nxt_irq_id = arb_id;
		nxt_irq_prio = arb_prio;
		nxt_int = |(nxt_evt_stat & evt_mask_ff);
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_ff <= '0;
			type_ff <= '0;
			prio_ff <= {N_IRQ{nvipst_pkg::PRIO_RST}};
			evt_stat_ff <= '0;
			evt_mask_ff <= nvipst_pkg::EVT_MASK_RST;
			dp_wr_ff <= 1'b0;
			dp_addr_ff <= '0;
			hrdata_ff <= nvipst_pkg::HRDATA_RST;
			irq_req_ff <= 1'b0;
			irq_id_ff <= '0;
			irq_prio_ff <= '0;
			int_ff <= 1'b0;
		end else begin
			enable_ff <= nxt_enable;
			type_ff <= nxt_type;
			prio_ff <= nxt_prio;
			evt_stat_ff <= nxt_evt_stat;
			evt_mask_ff <= nxt_evt_mask;
			dp_wr_ff <= nxt_dp_wr;
			dp_addr_ff <= nxt_dp_addr;
			hrdata_ff <= nxt_hrdata;
			irq_req_ff <= nxt_irq_req;
			irq_id_ff <= nxt_irq_id;
			irq_prio_ff <= nxt_irq_prio;
			int_ff <= nxt_int;
		end
	end

	// slave never stalls and always answers okay
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_hreadyout <= 1'b1;
			o_hresp <= nvipst_pkg::HRESP_OKAY;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= nvipst_pkg::HRESP_OKAY;
		end
	end

	assign o_hrdata = hrdata_ff;
	assign o_irq_req = irq_req_ff;
	assign o_irq_id = irq_id_ff;
	assign o_irq_prio = irq_prio_ff;
	assign o_int = int_ff;
endmodule

// >>> bench/nvipst_top_chk.sv
// port assertions for the interrupt pending state tracker
`timescale 1ns/1ps
module nvipst_top_chk #(
	parameter int N_IRQ = 21
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [N_IRQ-1:0] i_irq_line,
	input wire logic i_enter,
	input wire logic [$clog2(N_IRQ)-1:0] i_enter_id,
	input wire logic i_return,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic [31:0] o_hrdata,
	input wire logic o_irq_req,
	input wire logic [$clog2(N_IRQ)-1:0] o_irq_id,
	input wire logic [nvipst_pkg::PRIO_W-1:0] o_irq_prio,
	input wire logic o_int
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence s_rd(logic [7:0] a);
		i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_haddr[7:0] == a;
	endsequence
	sequence s_quiet;
		!(i_hsel && i_htrans[1]) && !i_enter && !i_return && $stable(i_irq_line);
	endsequence
	sequence s_en_off;
		i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr[7:0] == nvipst_pkg::OFS_ENABLE
		##1 i_hwdata == 32'h0000_0000;
	endsequence
	a_hresp_okay: assert property (o_hresp == nvipst_pkg::HRESP_OKAY) else $error("response not okay");
	a_ready_high: assert property (o_hreadyout) else $error("slave not ready");
	a_id_range: assert property (o_irq_req |-> int'(o_irq_id) < N_IRQ) else $error("request id out of range");
	a_reset_quiet: assert property ($rose(i_rst_b) |-> !o_irq_req && !o_int && o_hrdata == 32'h0000_0000)
		else $error("outputs not cleared by reset");
	a_enter_clears: assert property (i_enter && o_irq_req && i_enter_id == o_irq_id |=>
		##1 !(o_irq_req && o_irq_id == $past(i_enter_id, 2))) else $error("entered line still requested");
	a_unmapped_zero: assert property (s_rd(8'h3C) |=> o_hrdata == 32'h0000_0000) else $error("unmapped read not zero");
	a_arb_mirror: assert property (s_rd(nvipst_pkg::OFS_ARB) |=>
		o_hrdata == {$past(o_irq_req), 20'h00000, $past(o_irq_prio), 3'h0, $past(o_irq_id)})
		else $error("arbiter word differs from outputs");
	a_state_holds: assert property (s_quiet [*3] |=> $stable(o_irq_req) && $stable(o_irq_id))
		else $error("request changed with no cause");
	a_enable_gates: assert property (s_en_off |=> ##1 !o_irq_req) else $error("request with all lines disabled");
endmodule

bind nvipst_top nvipst_top_chk #(.N_IRQ(N_IRQ)) u_chk (
	.i_ref_clk(i_ref_clk),
	.i_rst_b(i_rst_b),
	.i_irq_line(i_irq_line),
	.i_enter(i_enter),
	.i_enter_id(i_enter_id),
	.i_return(i_return),
	.i_hsel(i_hsel),
	.i_haddr(i_haddr),
	.i_htrans(i_htrans),
	.i_hwrite(i_hwrite),
	.i_hwdata(i_hwdata),
	.i_hready(i_hready),
	.o_hreadyout(o_hreadyout),
	.o_hresp(o_hresp),
	.o_hrdata(o_hrdata),
	.o_irq_req(o_irq_req),
	.o_irq_id(o_irq_id),
	.o_irq_prio(o_irq_prio),
	.o_int(o_int)
);

// >>> bench/nvipst_peer.sv
// request sources and core strobes facing the tracker
`timescale 1ns/1ps
module nvipst_peer #(
	parameter int N_IRQ = 21
) (
	input wire logic i_clk,
	output logic [N_IRQ-1:0] o_line,
	output logic o_enter,
	output logic [$clog2(N_IRQ)-1:0] o_enter_id,
	output logic o_ret,
	output logic [$clog2(N_IRQ)-1:0] o_ret_id
);
	localparam int ID_W = $clog2(N_IRQ);
	initial begin
		o_line = '0;
		o_enter = 1'b0;
		o_ret = 1'b0;
	end
	// pulse held high for one whole cycle
	task pulse(input int n);
		@(posedge i_clk);
		o_line[n] <= 1'b1;
		@(posedge i_clk);
		o_line[n] <= 1'b0;
	endtask
	// level held until the caller drops it after service
	task level(input int n, input logic v);
		@(posedge i_clk);
		o_line[n] <= v;
	endtask
	task enter(input int id);
		@(posedge i_clk);
		o_enter <= 1'b1;
		o_enter_id <= ID_W'(id);
		@(posedge i_clk);
		o_enter <= 1'b0;
	endtask
	task ret(input int id);
		@(posedge i_clk);
		o_ret <= 1'b1;
		o_ret_id <= ID_W'(id);
		@(posedge i_clk);
		o_ret <= 1'b0;
	endtask
endmodule

// >>> bench/nvipst_top_bench.sv
// register and service sequences against the tracker
`timescale 1ns/1ps
module nvipst_top_bench;
	localparam int N_IRQ = 21;
	logic i_ref_clk, i_rst_b, i_enter, i_return, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp, o_irq_req, o_int;
	logic [N_IRQ-1:0] i_irq_line;
	logic [4:0] i_enter_id, i_return_id, o_irq_id;
	logic [31:0] i_haddr, i_hwdata, o_hrdata;
	logic [1:0] i_htrans;
	logic [2:0] i_hsize, o_irq_prio;
	int failures, comparisons;
	assign i_hready = o_hreadyout;
	nvipst_peer #(.N_IRQ(N_IRQ)) peer (.i_clk(i_ref_clk), .o_line(i_irq_line), .o_enter(i_enter),
		.o_enter_id(i_enter_id), .o_ret(i_return), .o_ret_id(i_return_id));
	nvipst_top #(.N_IRQ(N_IRQ)) dut (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_irq_line(i_irq_line),
		.i_enter(i_enter),
		.i_enter_id(i_enter_id),
		.i_return(i_return),
		.i_return_id(i_return_id),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hsize(i_hsize),
		.i_hwdata(i_hwdata),
		.i_hready(i_hready),
		.o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp),
		.o_hrdata(o_hrdata),
		.o_irq_req(o_irq_req),
		.o_irq_id(o_irq_id),
		.o_irq_prio(o_irq_prio),
		.o_int(o_int)
	);
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	task test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("wrong value %0s expected %h seen %h", n, e, g);
		end
	endtask
	task ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge i_ref_clk);
		i_hsel <= 1'b1;
		i_haddr <= {24'h000000, a};
		i_hwrite <= w;
		i_hsize <= 3'b010;
		i_htrans <= 2'b10;
		k = 0;
		do begin
			@(posedge i_ref_clk);
			k++;
		end while (i_hready !== 1'b1 && k < 16);
		i_htrans <= 2'b00;
		i_hwdata <= d;
		do begin
			@(posedge i_ref_clk);
			k++;
		end while (i_hready !== 1'b1 && k < 32);
		q = o_hrdata;
		i_hsel <= 1'b0;
		if (i_hready !== 1'b1) begin
			failures++;
			test_done();
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(a, 1'b1, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] q;
		ahb(a, 1'b0, 32'h0000_0000, q);
		chk(n, e, q);
	endtask
	task pause(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	initial begin
		i_hsel = 1'b0;
		i_htrans = 2'b00;
		failures = 0;
		comparisons = 0;
		i_rst_b = 1'b0;
		pause(2);
		i_rst_b <= 1'b1;
		pause(3);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0000, "pending");
		rd(nvipst_pkg::OFS_ACTIVE, 32'h0000_0000, "active");
		rd(8'h3C, 32'h0000_0000, "unmapped");
		$display("test reset ended");
		wr(nvipst_pkg::OFS_TYPE, 32'h0000_0020);
		wr(nvipst_pkg::OFS_ENABLE, 32'h001F_FFFF);
		wr(nvipst_pkg::OFS_PRIO0, 32'h0020_50F0);
		rd(nvipst_pkg::OFS_PRIO0, 32'h0020_5070, "prio0");
		wr(nvipst_pkg::OFS_PRIO2, 32'hFFFF_FFFF);
		rd(nvipst_pkg::OFS_PRIO2, 32'h0007_7777, "prio2");
		wr(nvipst_pkg::OFS_SET_PEND, 32'h0000_0028);
		rd(nvipst_pkg::OFS_ARB, 32'h8000_0205, "arb");
		peer.enter(5);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0008, "pending");
		rd(nvipst_pkg::OFS_ACTIVE, 32'h0000_0020, "active");
		rd(nvipst_pkg::OFS_ARB, 32'h8000_0503, "arb");
		chk("irq_id", 32'h0000_0003, {27'h0, o_irq_id});
		chk("irq_prio", 32'h0000_0005, {29'h0, o_irq_prio});
		$display("test priority ended");
		peer.pulse(5);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0028, "pending");
		wr(nvipst_pkg::OFS_CLR_PEND, 32'h0000_0020);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0008, "pending");
		rd(nvipst_pkg::OFS_ACTIVE, 32'h0000_0020, "active");
		peer.pulse(5);
		peer.ret(5);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0028, "pending");
		rd(nvipst_pkg::OFS_ACTIVE, 32'h0000_0000, "active");
		peer.enter(5);
		peer.ret(5);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0008, "pending");
		wr(nvipst_pkg::OFS_CLR_PEND, 32'h0000_0028);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0000, "pending");
		$display("test pulse ended");
		peer.level(3, 1'b1);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0008, "pending");
		wr(nvipst_pkg::OFS_CLR_PEND, 32'h0000_0008);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0008, "pending");
		peer.enter(3);
		pause(4);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0000, "pending");
		peer.ret(3);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0008, "pending");
		peer.enter(3);
		peer.level(3, 1'b0);
		peer.ret(3);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0000, "pending");
		$display("test level ended");
		wr(nvipst_pkg::OFS_SOFTWARE_IRQ_TRIGGER, 32'h0000_0007);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0080, "pending");
		wr(nvipst_pkg::OFS_CLR_PEND, 32'h0000_0080);
		peer.pulse(5);
		pause(3);
		rd(nvipst_pkg::OFS_SET_PEND, 32'h0000_0020, "pending");
		$display("test trigger ended");
		rd(nvipst_pkg::OFS_EVT_STAT, 32'h0000_0007, "events");
		chk("int", 32'h0000_0000, {31'h0, o_int});
		wr(nvipst_pkg::OFS_EVT_MASK, 32'h0000_0002);
		pause(2);
		chk("int", 32'h0000_0001, {31'h0, o_int});
		wr(nvipst_pkg::OFS_EVT_STAT, 32'h0000_0007);
		rd(nvipst_pkg::OFS_EVT_STAT, 32'h0000_0000, "events");
		chk("int", 32'h0000_0000, {31'h0, o_int});
		wr(nvipst_pkg::OFS_ENABLE, 32'h0000_0000);
		pause(3);
		chk("irq_req", 32'h0000_0000, {31'h0, o_irq_req});
		$display("test events ended");
		test_done();
	end
endmodule
